// >>> bench/icesp_cpu_model.sv
`timescale 1ns/10ps
module icesp_cpu_model
  import icesp_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output icesp_ahb_s bus
);
  initial bus = '0;

  // single word transfer; each phase held until hready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic ns, input icesp_cpu_t cpu, output logic [31:0] r);
    @(posedge hclk);
    bus.hsel <= 1'b1;
    bus.htrans <= ICESP_HTRANS_NONSEQ;
    bus.haddr <= {20'h00000, a};
    bus.hwrite <= w;
    bus.hsize <= 3'h2;
    bus.hnonsec <= ns;
    bus.hmaster <= cpu;
    do @(posedge hclk); while (hready !== 1'b1);
    bus.hsel <= 1'b0;
    bus.htrans <= 2'h0;
    bus.hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
endmodule : icesp_cpu_model

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import icesp_pkg::*;
;
  logic hclk;
  logic hresetn;
  logic cfg_lock_pin;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] r;
  icesp_ahb_s bus;
  icesp_ahb_s ahb;
  icesp_evt_s evt;
  icesp_irq_s irq;
  int n_errors;
  int n_tests;

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // single slave: its hreadyout is the bus hready
  always_comb begin
    ahb = bus;
    ahb.hready = hreadyout;
  end

  icesp_dist_regs u_dut (.hclk(hclk), .hresetn(hresetn), .ahb(ahb), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .cfg_lock_pin(cfg_lock_pin),
    .irq(irq));
  icesp_cpu_model u_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .bus(bus));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic ns, input icesp_cpu_t cpu,
                    input logic [31:0] exp);
    u_cpu.xfer(1'b0, a, 32'h0000_0000, ns, cpu, r);
    chk(r, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns,
                    input icesp_cpu_t cpu);
    u_cpu.xfer(1'b1, a, d, ns, cpu, r);
  endtask : wr

  task automatic end_of_test;
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (1000) @(posedge hclk);
    n_errors++;
    end_of_test();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    hresetn = 1'b0;
    cfg_lock_pin = 1'b0;
    evt = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // ids 40-47 non-secure, all others secure
    evt.group[1] <= 32'h0000_ff00;
    rd(12'h180, 1'b0, 1'b0, 32'h0000_ffff);
    wr(12'h180, 32'hffff_ffff, 1'b0, 1'b0);
    rd(12'h180, 1'b0, 1'b0, 32'h0000_ffff);
    // banked register zero per processor
    wr(12'h100, 32'hffff_0000, 1'b0, 1'b1);
    rd(12'h180, 1'b0, 1'b1, 32'hffff_ffff);
    wr(12'h180, 32'h0001_0000, 1'b0, 1'b1);
    rd(12'h180, 1'b0, 1'b1, 32'hfffe_ffff);
    chk(irq.en0[0], 32'h0000_ffff);
    // peripheral enables through both views
    wr(12'h104, 32'hffff_ffff, 1'b0, 1'b0);
    rd(12'h184, 1'b0, 1'b0, 32'h0fff_ffff);
    wr(12'h184, 32'h0000_0003, 1'b0, 1'b1);
    rd(12'h184, 1'b0, 1'b0, 32'h0fff_fffc);
    chk(irq.en_spi[0], 32'h0fff_fffc);
    rd(12'h184, 1'b1, 1'b0, 32'h0000_ff00);
    wr(12'h184, 32'hffff_ffff, 1'b1, 1'b0);
    rd(12'h184, 1'b0, 1'b0, 32'h0fff_00fc);
    rd(12'h188, 1'b0, 1'b0, 32'h0000_0000);
    rd(12'h300, 1'b0, 1'b0, 32'h0000_0000);
    wr(12'h188, 32'hffff_ffff, 1'b0, 1'b0);
    wr(12'h300, 32'hffff_ffff, 1'b0, 1'b0);
    rd(12'h184, 1'b0, 1'b0, 32'h0fff_00fc);
    // hardware event on a disabled interrupt still pends
    @(posedge hclk);
    evt.set_spi[0] <= 32'h0000_0001;
    @(posedge hclk);
    evt.set_spi[0] <= 32'h0000_0000;
    rd(12'h204, 1'b0, 1'b0, 32'h0000_0001);
    wr(12'h200, 32'hffff_ffff, 1'b0, 1'b1);
    rd(12'h200, 1'b0, 1'b1, 32'hffff_0000);
    rd(12'h200, 1'b0, 1'b0, 32'h0000_0000);
    chk(irq.pend0[1], 32'hffff_0000);
    @(posedge hclk);
    evt.set0[0] <= 32'h0010_0000;
    @(posedge hclk);
    evt.set0[0] <= 32'h0000_0000;
    rd(12'h200, 1'b0, 1'b0, 32'h0010_0000);
    // lockdown protects secure lockable peripheral bits
    @(posedge hclk);
    cfg_lock_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    wr(12'h184, 32'hffff_ffff, 1'b0, 1'b0);
    rd(12'h184, 1'b0, 1'b0, 32'h0000_00fc);
    wr(12'h204, 32'hffff_ffff, 1'b0, 1'b0);
    rd(12'h204, 1'b0, 1'b0, 32'h0fff_ff01);
    rd(12'h204, 1'b1, 1'b0, 32'h0000_ff00);
    chk(irq.pend_spi[0], 32'h0fff_ff01);
    chk({31'h0, hresp}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
    end_of_test();
  end
endmodule : tb_top

// >>> hdl/icesp_dist_regs.sv
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
module icesp_dist_regs
  import icesp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire icesp_ahb_s ahb,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire icesp_evt_s evt,
  input wire logic cfg_lock_pin,
  output icesp_irq_s irq
);

  function automatic logic [31:0] icesp_rmask(input int unsigned idx, input logic ns,
                                              input icesp_grp_t grp);
    logic [31:0] m;
    m = ICESP_IMPL[idx];
    if (ICESP_SEC_EXT && ns) begin
      m = m & grp[idx];
    end
    return m;
  endfunction : icesp_rmask

  function automatic logic [31:0] icesp_wmask(input int unsigned idx, input logic ns,
                                              input icesp_grp_t grp, input logic lock);
    logic [31:0] lk;
    lk = {32{lock && ICESP_LOCK_IMPL && ICESP_SEC_EXT}} & ICESP_LOCKABLE[idx] & ~grp[idx];
    return icesp_rmask(idx, ns, grp) & ~lk;
  endfunction : icesp_wmask

  function automatic logic [31:0] icesp_word(input icesp_bank_t bank, input icesp_spi_t spi,
                                             input int unsigned idx, input icesp_cpu_t cpu);
    logic [31:0] w;
    if (idx == 0) begin
      w = bank[cpu];
    end else begin
      w = spi[idx-1];
    end
    return w;
  endfunction : icesp_word

  function automatic logic [31:0] icesp_read(input icesp_irq_s st, input logic [11:0] addr,
                                             input logic ns, input icesp_cpu_t cpu,
                                             input icesp_grp_t grp);
    int unsigned idx;
    logic [31:0] w;
    idx = int'(addr[6:2]);
    w = 32'h0000_0000;
    if (idx < ICESP_NREG) begin
      if (addr[11:7] == ICESP_OFF_SET_EN[11:7] || addr[11:7] == ICESP_OFF_CLR_EN[11:7]) begin
        w = icesp_word(st.en0, st.en_spi, idx, cpu) & icesp_rmask(idx, ns, grp);
      end else if (addr[11:7] == ICESP_OFF_SET_PEND[11:7]) begin
        w = icesp_word(st.pend0, st.pend_spi, idx, cpu) & icesp_rmask(idx, ns, grp);
      end
    end
    return w;
  endfunction : icesp_read

  icesp_state_s s;
  icesp_state_s next_s;

  int unsigned d_idx;
  int unsigned d_spi;
  logic d_valid;
  logic d_set_en;
  logic d_clr_en;
  logic d_set_pend;
  logic lock;
  logic [31:0] wm;
  logic [31:0] w_bits;
  logic [31:0] w_nosgi;
  logic a_take;

  // data-phase decode of the held address
  assign d_idx = int'(s.daddr[6:2]);
  assign d_spi = (d_idx == 0) ? 0 : d_idx - 1;
  assign d_valid = s.dwr && (d_idx < ICESP_NREG);
  assign d_set_en = d_valid && (s.daddr[11:7] == ICESP_OFF_SET_EN[11:7]);
  assign d_clr_en = d_valid && (s.daddr[11:7] == ICESP_OFF_CLR_EN[11:7]);
  assign d_set_pend = d_valid && (s.daddr[11:7] == ICESP_OFF_SET_PEND[11:7]);
  assign lock = s.lock_sync[1];
  // secure and non-secure reach one copy, masked by group
  assign wm = d_valid ? icesp_wmask(d_idx, s.dns, evt.group, lock) : 32'h0000_0000;
  assign w_bits = wm & ahb.hwdata;
  assign w_nosgi = (d_idx == 0) ? (w_bits & ~ICESP_SGI_BITS) : w_bits;
  assign a_take = ahb.hsel && ahb.hready && (ahb.htrans == ICESP_HTRANS_NONSEQ);

  always_comb begin
    next_s = s;
    next_s.lock_sync = {s.lock_sync[0], cfg_lock_pin};
    // events keep driving pending whatever the enable, set beats clear
    for (int c = 0; c < ICESP_NCPU; c++) begin
      next_s.irq.pend0[c] = ((s.irq.pend0[c] & ~evt.clr0[c]) | evt.set0[c]) & ICESP_IMPL[0];
    end
    for (int r = 0; r < ICESP_NREG - 1; r++) begin
      next_s.irq.pend_spi[r] = ((s.irq.pend_spi[r] & ~evt.clr_spi[r]) | evt.set_spi[r])
                               & ICESP_IMPL[r+1];
    end
    if (d_set_en) begin
      if (d_idx == 0) begin
        next_s.irq.en0[s.dcpu] = s.irq.en0[s.dcpu] | w_nosgi;
      end else begin
        next_s.irq.en_spi[d_spi] = s.irq.en_spi[d_spi] | w_bits;
      end
    end
    if (d_clr_en) begin
      if (d_idx == 0) begin
        next_s.irq.en0[s.dcpu] = s.irq.en0[s.dcpu] & ~w_nosgi;
      end else begin
        next_s.irq.en_spi[d_spi] = s.irq.en_spi[d_spi] & ~w_bits;
      end
    end
    if (d_set_pend) begin
      if (d_idx == 0) begin
        next_s.irq.pend0[s.dcpu] = next_s.irq.pend0[s.dcpu] | w_nosgi;
      end else begin
        next_s.irq.pend_spi[d_spi] = next_s.irq.pend_spi[d_spi] | w_bits;
      end
    end
    next_s.dwr = 1'b0;
    if (a_take) begin
      next_s.dwr = ahb.hwrite;
      next_s.daddr = ahb.haddr[11:0];
      next_s.dns = ahb.hnonsec;
      next_s.dcpu = ahb.hmaster;
      if (!ahb.hwrite) begin
        // read sees the write finishing in this same cycle
        next_s.hrdata = icesp_read(next_s.irq, ahb.haddr[11:0], ahb.hnonsec, ahb.hmaster,
                                   evt.group);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.irq.en0 <= {ICESP_NCPU{ICESP_EN0_RST}};
      s.irq.pend0 <= {ICESP_NCPU{ICESP_PEND_RST}};
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = s.irq;

  // checks
  logic [31:0] h_en_now;
  logic [31:0] h_pend_now;
  logic h_evt_idle;
  assign h_en_now = icesp_word(s.irq.en0, s.irq.en_spi, d_spi + (d_idx == 0 ? 0 : 1), s.dcpu);
  assign h_pend_now = icesp_word(s.irq.pend0, s.irq.pend_spi, d_idx < ICESP_NREG ? d_idx : 0,
                                 s.dcpu);
  assign h_evt_idle = (evt.set0 == '0) && (evt.clr0 == '0);

  a_clr_en_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    d_clr_en && !d_set_en |=> (icesp_word(s.irq.en0, s.irq.en_spi, $past(d_idx), $past(s.dcpu))
      & $past(w_nosgi)) == 32'h0000_0000)
    else $error("clear-enable write left an enable set");

  a_clr_en_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    d_clr_en |=> (icesp_word(s.irq.en0, s.irq.en_spi, $past(d_idx), $past(s.dcpu))
      & ~$past(w_nosgi)) == ($past(h_en_now) & ~$past(w_nosgi)))
    else $error("clear-enable write changed a bit written zero");

  a_rd_en_view: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_CLR_EN
      && !ahb.hnonsec |=> hrdata == (s.irq.en0[$past(ahb.hmaster)] & ICESP_IMPL[0]))
    else $error("clear-enable read disagrees with enable state");

  a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ((s.irq.en_spi[0] | s.irq.pend_spi[0]) & ~ICESP_IMPL[1]) == 32'h0000_0000)
    else $error("unimplemented interrupt bit is set");

  a_ns_hide: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && ahb.hnonsec ##1 1'b1
      |-> (hrdata & ~evt.group[$past(ahb.haddr[6:2]) < ICESP_NREG ? $past(ahb.haddr[6:2]) : 0])
      == 32'h0000_0000 || $past(ahb.haddr[6:2]) >= ICESP_NREG)
    else $error("non-secure read exposed a secure bit");

  a_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    d_valid && d_idx == 1 && lock && !d_set_pend
      |=> (s.irq.en_spi[0] & ICESP_LOCKABLE[1] & ~$past(evt.group[1]))
      == ($past(s.irq.en_spi[0]) & ICESP_LOCKABLE[1] & ~$past(evt.group[1])))
    else $error("locked enable bit was modified");

  a_sgi_pend_ro: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend && d_idx == 0 && h_evt_idle
      |=> (s.irq.pend0[$past(s.dcpu)] & ICESP_SGI_BITS) == ($past(h_pend_now) & ICESP_SGI_BITS))
    else $error("software interrupt pending bit written");

  a_set_pend_hit: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend |=> (icesp_word(s.irq.pend0, s.irq.pend_spi, $past(d_idx), $past(s.dcpu))
      & $past(w_nosgi)) == $past(w_nosgi))
    else $error("set-pending write did not make pending");

  a_evt_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.set_spi[0] & ICESP_IMPL[1] & ~s.irq.en_spi[0]) != 32'h0000_0000
      |=> (s.irq.pend_spi[0] & $past(evt.set_spi[0] & ICESP_IMPL[1])) == $past(evt.set_spi[0]
      & ICESP_IMPL[1]))
    else $error("disabled interrupt failed to become pending");

  a_bank_sep: assert property (@(posedge hclk) disable iff (!hresetn)
    d_valid && d_idx == 0 && !d_set_pend
      |=> s.irq.en0[!$past(s.dcpu)] == $past(s.irq.en0[!s.dcpu]))
    else $error("register zero write reached another processor bank");

  a_rd_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && ahb.haddr[6:2] >= ICESP_NREG
    |=> hrdata == 32'h0000_0000)
    else $error("read beyond the implemented registers returned data");

  a_rd_off_map: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && ahb.haddr[11:7] != ICESP_OFF_SET_EN[11:7]
      && ahb.haddr[11:7] != ICESP_OFF_CLR_EN[11:7]
      && ahb.haddr[11:7] != ICESP_OFF_SET_PEND[11:7]
    |=> hrdata == 32'h0000_0000)
    else $error("read outside the register arrays returned data");

  a_rd_pend_bank: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_SET_PEND
      && !ahb.hnonsec
    |=> hrdata == s.irq.pend0[$past(ahb.hmaster)])
    else $error("banked set-pending read disagrees with pending state");

  a_rd_pend_spi: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_SET_PEND + 12'h004
      && !ahb.hnonsec
    |=> hrdata == s.irq.pend_spi[0])
    else $error("peripheral set-pending read disagrees with pending state");

  a_rd_en_spi: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_CLR_EN + 12'h004
      && !ahb.hnonsec
    |=> hrdata == s.irq.en_spi[0])
    else $error("peripheral clear-enable read disagrees with enable state");

  a_rd_set_view: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_SET_EN
      && !ahb.hnonsec
    |=> hrdata == s.irq.en0[$past(ahb.hmaster)])
    else $error("set-enable view disagrees with enable state");

  a_rd_ns_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_SET_PEND + 12'h004
      && ahb.hnonsec
    |=> hrdata == (s.irq.pend_spi[0] & $past(evt.group[1])))
    else $error("non-secure pending read shows wrong bits");

  a_rd_ns_en: assert property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && !s.dwr && ahb.haddr[11:0] == ICESP_OFF_CLR_EN + 12'h004
      && ahb.hnonsec
    |=> hrdata == (s.irq.en_spi[0] & $past(evt.group[1])))
    else $error("non-secure enable read shows wrong bits");

  a_sgi_en_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.irq.en0[0] & ICESP_SGI_BITS) == ICESP_SGI_BITS
      && (s.irq.en0[1] & ICESP_SGI_BITS) == ICESP_SGI_BITS)
    else $error("software interrupt enable was cleared");

  a_clr_spi_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    d_clr_en && d_idx == 1
    |=> (s.irq.en_spi[0] & $past(w_bits)) == 32'h0000_0000)
    else $error("cleared peripheral enable still reads one");

  a_set_en_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_en
    |=> (icesp_word(s.irq.en0, s.irq.en_spi, $past(d_idx), $past(s.dcpu))
      & $past(w_nosgi)) == $past(w_nosgi))
    else $error("set-enable write did not reach the shared enable");

  a_ns_en_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    d_valid && s.dns && d_idx == 1
    |=> ((s.irq.en_spi[0] ^ $past(s.irq.en_spi[0])) & ~$past(evt.group[1]))
      == 32'h0000_0000)
    else $error("non-secure write changed a secure enable");

  a_ns_pend_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend && s.dns && d_idx == 1 && evt.set_spi == '0 && evt.clr_spi == '0
    |=> ((s.irq.pend_spi[0] ^ $past(s.irq.pend_spi[0])) & ~$past(evt.group[1]))
      == 32'h0000_0000)
    else $error("non-secure write changed a secure pending bit");

  a_lock_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend && d_idx == 1 && lock && evt.set_spi == '0 && evt.clr_spi == '0
    |=> (s.irq.pend_spi[0] & ICESP_LOCKABLE[1] & ~$past(evt.group[1]))
      == ($past(s.irq.pend_spi[0]) & ICESP_LOCKABLE[1] & ~$past(evt.group[1])))
    else $error("locked pending bit was modified");

  a_lock_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    lock == $past(cfg_lock_pin, 2))
    else $error("lock request not seen two edges after the pin");

  a_bank_pend_sep: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend && d_idx == 0 && h_evt_idle
    |=> s.irq.pend0[!$past(s.dcpu)] == $past(s.irq.pend0[!s.dcpu]))
    else $error("pending write reached another processor bank");

  a_wr_unmapped: assert property (@(posedge hclk) disable iff (!hresetn)
    s.dwr && d_idx >= ICESP_NREG
    |=> $stable(s.irq.en0) && $stable(s.irq.en_spi))
    else $error("write beyond the implemented registers changed an enable");

  a_wr_off_map: assert property (@(posedge hclk) disable iff (!hresetn)
    s.dwr && !d_set_en && !d_clr_en && !d_set_pend
    |=> $stable(s.irq.en0) && $stable(s.irq.en_spi))
    else $error("unmapped write changed an enable");

  a_evt_pend_bank: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.set0[0] & ~s.irq.en0[0]) != 32'h0000_0000
    |=> (s.irq.pend0[0] & $past(evt.set0[0])) == $past(evt.set0[0]))
    else $error("disabled banked interrupt failed to become pending");

  a_pend_keep_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend && d_idx == 1 && evt.set_spi == '0 && evt.clr_spi == '0
    |=> (s.irq.pend_spi[0] & ~$past(w_bits))
      == ($past(s.irq.pend_spi[0]) & ~$past(w_bits)))
    else $error("set-pending write changed a bit written zero");

  a_pend_stay: assert property (@(posedge hclk) disable iff (!hresetn)
    d_set_pend && d_idx == 1 && evt.clr_spi == '0
    |=> (s.irq.pend_spi[0] & $past(s.irq.pend_spi[0])) == $past(s.irq.pend_spi[0]))
    else $error("set-pending write dropped a pending bit");

  a_ns_clr_common: assert property (@(posedge hclk) disable iff (!hresetn)
    d_clr_en && s.dns && d_idx == 1
    |=> (s.irq.en_spi[0] & $past(w_bits)) == 32'h0000_0000)
    else $error("non-secure clear missed the common enable copy");

  a_clr_bank0: assert property (@(posedge hclk) disable iff (!hresetn)
    d_clr_en && d_idx == 0
    |=> (s.irq.en0[$past(s.dcpu)] & $past(w_nosgi)) == 32'h0000_0000)
    else $error("banked clear-enable write left an enable set");

  c_evt_pend: cover property (@(posedge hclk) disable iff (!hresetn)
    (evt.set0[0] | evt.set_spi[0]) != 32'h0000_0000);
  c_clr_write: cover property (@(posedge hclk) disable iff (!hresetn) d_clr_en && wm != '0);
  c_pend_write: cover property (@(posedge hclk) disable iff (!hresetn) d_set_pend && d_idx == 1);
  c_ns_read: cover property (@(posedge hclk) disable iff (!hresetn)
    a_take && !ahb.hwrite && ahb.hnonsec);
  c_lock_write: cover property (@(posedge hclk) disable iff (!hresetn) d_valid && lock);

endmodule : icesp_dist_regs

// >>> hdl/icesp_pkg.sv
package icesp_pkg;
  localparam int ICESP_NCPU = 2;
  // interrupt_line_count_field value
  localparam int ICESP_ITLINES = 1;
  localparam int ICESP_NREG = ICESP_ITLINES + 1;
  localparam logic [11:0] ICESP_OFF_SET_EN = 12'h100;
  localparam logic [11:0] ICESP_OFF_CLR_EN = 12'h180;
  localparam logic [11:0] ICESP_OFF_SET_PEND = 12'h200;
  localparam logic ICESP_SEC_EXT = 1'b1;
  localparam logic ICESP_LOCK_IMPL = 1'b1;
  // software_generated_interrupt bits of register zero
  localparam logic [31:0] ICESP_SGI_BITS = 32'h0000_ffff;
  // software_generated_interrupt are permanently enabled
  localparam logic [31:0] ICESP_EN0_RST = 32'h0000_ffff;
  localparam logic [31:0] ICESP_PEND_RST = 32'h0000_0000;
  localparam logic [ICESP_NREG-1:0][31:0] ICESP_IMPL = {32'h0fff_ffff, 32'hffff_ffff};
  localparam logic [ICESP_NREG-1:0][31:0] ICESP_LOCKABLE = {32'h0000_00ff, 32'h0000_0000};
  localparam logic [1:0] ICESP_HTRANS_NONSEQ = 2'h2;

  typedef logic [ICESP_NCPU-1:0][31:0] icesp_bank_t;
  typedef logic [ICESP_NREG-2:0][31:0] icesp_spi_t;
  typedef logic [ICESP_NREG-1:0][31:0] icesp_grp_t;
  typedef logic [$clog2(ICESP_NCPU)-1:0] icesp_cpu_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
    logic hnonsec;
    icesp_cpu_t hmaster;
  } icesp_ahb_s;

  typedef struct packed {
    icesp_bank_t set0;
    icesp_spi_t set_spi;
    icesp_bank_t clr0;
    icesp_spi_t clr_spi;
    icesp_grp_t group;
  } icesp_evt_s;

  typedef struct packed {
    icesp_bank_t en0;
    icesp_spi_t en_spi;
    icesp_bank_t pend0;
    icesp_spi_t pend_spi;
  } icesp_irq_s;

  typedef struct packed {
    icesp_irq_s irq;
    logic dwr;
    logic [11:0] daddr;
    logic dns;
    icesp_cpu_t dcpu;
    logic [31:0] hrdata;
    logic [1:0] lock_sync;
  } icesp_state_s;
endpackage : icesp_pkg
